// file: inc/sbu_map.svh
/*
 * Bit positions, opcodes and encodings for the store byte unit.
 * Assumes big-endian bit numbering: instruction bit 0 is the msb.
 */
// Summary of operation
// RULE_01 - opcode 38: plain store with displacement
// RULE_02 - opcode 39: displacement store with base update
// RULE_03 - opcode 31, extended 247: indexed update store
// RULE_04 - opcode 31, extended 215: indexed plain store
// RULE_05 - store only source bits 24-31, one byte
// RULE_06 - sign-extend 16-bit displacement to 32 bits
// RULE_07 - zero base field: address is displacement
// RULE_08 - indexed: base plus index register contents
// RULE_09 - indexed, zero base field: index alone
// RULE_10 - update base only if nonzero, no alignment fault
// RULE_11 - never touch exception or condition registers
// RULE_12 - source register never modified; code overwrites it on an update whose base field equals the source field
// RULE_13 - one memory write, address, byte, lane
`ifndef SBU_MAP_SVH
`define SBU_MAP_SVH
`define SBU_OP_STORE 6'h26
`define SBU_OP_STORE_UPD 6'h27
`define SBU_OP_EXT 6'h1f
`define SBU_XO_IDX_UPD 10'h0f7
`define SBU_XO_IDX 10'h0d7
`define SBU_REG_ZERO 5'h00
`define SBU_LANE_BYTE 4'h1
`endif

// file: inc/sbu_pkg.sv
/*
 * Types shared by the store byte unit.
 * Assumes sbu_map.svh holds the numeric constants.
 */
package sbu_pkg;
	typedef enum logic [2:0] {SBU_FORM_NONE, SBU_FORM_D, SBU_FORM_DU, SBU_FORM_X, SBU_FORM_XU} sbu_form_t;
	typedef struct packed {
		logic [5:0] opcode;
		logic [4:0] source_reg_field;
		logic [4:0] base_reg_field;
		logic [4:0] index_reg_field;
		logic [9:0] ext_opcode;
		logic reserved_bit;
	} sbu_instr_t;
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [7:0] data;
		logic [3:0] lanes;
	} sbu_store_t;
	typedef struct packed {
		logic en;
		logic [4:0] index;
		logic [31:0] data;
	} sbu_wb_t;
endpackage

// file: hdl/sbu_regfile.sv
/*
 * Register file of 32 words with three registered read ports and one write port.
 * Assumes reads are requested one cycle ahead of use.
 */
`timescale 1ns/1ns
module sbu_regfile (
	// clocking
	input wire logic clk,
	input wire logic ce,
	// read ports
	input wire logic [4:0] rd_a_index,
	input wire logic [4:0] rd_b_index,
	input wire logic [4:0] rd_c_index,
	output logic [31:0] rd_a_data,
	output logic [31:0] rd_b_data,
	output logic [31:0] rd_c_data,
	// write port
	input wire sbu_pkg::sbu_wb_t wr
);
	logic [31:0] mem [0:31];

	always_ff @(posedge clk) begin
		if (ce) begin
			if (wr.en) begin
				mem[wr.index] <= wr.data;
			end
			rd_a_data <= mem[rd_a_index];
			rd_b_data <= mem[rd_b_index];
			rd_c_data <= mem[rd_c_index];
		end
	end
endmodule

// file: hdl/sbu_top.sv
/*
 * Store byte unit: decodes the four byte-store forms, builds the effective
 * address, issues one byte write and updates the base register where asked.
 * Assumes one instruction at a time, a memory port that accepts every write,
 * and an alignment fault input valid in the execute cycle.
 */
`timescale 1ns/1ns
`include "sbu_map.svh"
module sbu_top (
	// clocking
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// instruction issue
	input wire logic instr_valid,
	input wire logic [31:0] instr_word,
	// register file preload from the core
	input wire sbu_pkg::sbu_wb_t gpr_load,
	// alignment fault reported by the memory side
	input wire logic align_fault,
	// memory store port
	output sbu_pkg::sbu_store_t store_reg,
	// status
	output logic illegal_reg,
	output logic busy_reg,
	output logic done_reg,
	output logic base_updated_reg
);
	////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC} sbu_state_t;
	sbu_state_t state_reg, state_next;
	sbu_pkg::sbu_instr_t ins_reg;
	sbu_pkg::sbu_form_t form_reg;
	wire sbu_pkg::sbu_instr_t ins_in = instr_word;

	function automatic sbu_pkg::sbu_form_t decode(input sbu_pkg::sbu_instr_t i);
		if (i.opcode == `SBU_OP_STORE) begin
			return sbu_pkg::SBU_FORM_D; // [RULE_01]
		end else if (i.opcode == `SBU_OP_STORE_UPD) begin
			return sbu_pkg::SBU_FORM_DU; // [RULE_02]
		end else if (i.opcode == `SBU_OP_EXT && i.ext_opcode == `SBU_XO_IDX_UPD) begin
			return sbu_pkg::SBU_FORM_XU; // [RULE_03]
		end else if (i.opcode == `SBU_OP_EXT && i.ext_opcode == `SBU_XO_IDX) begin
			return sbu_pkg::SBU_FORM_X; // [RULE_04]
		end
		return sbu_pkg::SBU_FORM_NONE;
	endfunction

	////////////////////////////////////////////////////////////////
	// decode and register reads
	wire sbu_pkg::sbu_form_t form_in = decode(ins_in);
	wire accept = (state_reg == ST_IDLE) && instr_valid;
	wire [15:0] disp = {ins_reg.index_reg_field, ins_reg.ext_opcode, ins_reg.reserved_bit};
	wire [31:0] disp_ext = {{16{disp[15]}}, disp}; // [RULE_06]
	wire is_disp = (form_reg == sbu_pkg::SBU_FORM_D) || (form_reg == sbu_pkg::SBU_FORM_DU);
	wire is_upd = (form_reg == sbu_pkg::SBU_FORM_DU) || (form_reg == sbu_pkg::SBU_FORM_XU);
	wire base_zero = ins_reg.base_reg_field == `SBU_REG_ZERO;
	logic [31:0] src_data, base_data, index_data;
	sbu_pkg::sbu_wb_t wb;

	// read-only ports keep the source register intact unless an update names it as base
	sbu_regfile u_regfile (
		.clk(clk),
		.ce(ce),
		.rd_a_index(ins_reg.source_reg_field),
		.rd_b_index(ins_reg.base_reg_field),
		.rd_c_index(ins_reg.index_reg_field),
		.rd_a_data(src_data),
		.rd_b_data(base_data),
		.rd_c_data(index_data),
		.wr(wb)
	); // [RULE_12]

	////////////////////////////////////////////////////////////////
	// address generation
	wire [31:0] base_val = base_zero ? 32'h0000_0000 : base_data; // [RULE_07] [RULE_09]
	wire [31:0] offset_val = is_disp ? disp_ext : index_data; // [RULE_08]
	wire [31:0] eff_addr = base_val + offset_val;
	wire do_exec = (state_reg == ST_EXEC);
	wire do_update = do_exec && is_upd && !base_zero && !align_fault; // [RULE_10]

	// core preload has priority only outside the update cycle
	assign wb.en = do_update || gpr_load.en;
	assign wb.index = do_update ? ins_reg.base_reg_field : gpr_load.index;
	assign wb.data = do_update ? eff_addr : gpr_load.data;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (instr_valid && form_in != sbu_pkg::SBU_FORM_NONE) begin
					state_next = ST_READ;
				end
			end
			ST_READ: begin
				state_next = ST_EXEC;
			end
			ST_EXEC: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// state and outputs; no exception or condition register output exists at all [RULE_11]
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			ins_reg <= '0;
			form_reg <= sbu_pkg::SBU_FORM_NONE;
		end else if (ce) begin
			state_reg <= state_next;
			if (accept) begin
				ins_reg <= ins_in;
				form_reg <= form_in;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			store_reg <= '0;
			illegal_reg <= 1'b0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			base_updated_reg <= 1'b0;
		end else if (ce) begin
			store_reg.valid <= do_exec && !align_fault; // [RULE_13]
			store_reg.addr <= do_exec ? eff_addr : store_reg.addr;
			store_reg.data <= do_exec ? src_data[7:0] : store_reg.data; // [RULE_05]
			// lane only beside a real write, so a faulted store shows no lane
			store_reg.lanes <= (do_exec && !align_fault) ? `SBU_LANE_BYTE : 4'h0; // [RULE_13]
			illegal_reg <= accept && (form_in == sbu_pkg::SBU_FORM_NONE);
			busy_reg <= state_next != ST_IDLE;
			done_reg <= do_exec;
			base_updated_reg <= do_update;
		end
	end
endmodule

// file: dv/sbu_assertions.sv
/* port checks for sbu_top
 * assumes ce held high */
`timescale 1ns/1ns
`include "sbu_map.svh"
module sbu_checker (
	// control
	input wire logic clk,
	input wire logic resetn,
	input wire logic instr_valid,
	input wire logic [31:0] instr_word,
	input wire logic align_fault,
	// results
	input wire sbu_pkg::sbu_store_t store_reg,
	input wire logic illegal_reg,
	input wire logic busy_reg,
	input wire logic done_reg,
	input wire logic base_updated_reg
);
	wire logic [5:0] op = instr_word[31:26];
	wire logic [9:0] xo = instr_word[10:1];
	wire logic take = instr_valid && !busy_reg;
	wire logic legal = op == `SBU_OP_STORE || op == `SBU_OP_STORE_UPD ||
		op == `SBU_OP_EXT && (xo == `SBU_XO_IDX || xo == `SBU_XO_IDX_UPD);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	chk_legal_taken: assert property (take && legal |=> busy_reg && !illegal_reg)
		else $error("store refused");
	chk_illegal_flag: assert property (take && !legal |=> illegal_reg && !busy_reg)
		else $error("bad word taken");
	chk_exec_latency: assert property ($rose(busy_reg) |-> busy_reg ##1 !done_reg ##1 done_reg && !busy_reg)
		else $error("bad latency");
	chk_single_write: assert property (store_reg.valid |-> done_reg ##1 !store_reg.valid)
		else $error("write not single");
	chk_lane_only: assert property (store_reg.lanes == (store_reg.valid ? 4'h1 : 4'h0))
		else $error("bad lanes");
	chk_fault_blocks: assert property (busy_reg && align_fault ##1 done_reg |-> !store_reg.valid && !base_updated_reg)
		else $error("fault ignored");
	chk_update_store: assert property (base_updated_reg |-> store_reg.valid)
		else $error("update without store");
	chk_done_pulse: assert property (done_reg |=> !done_reg)
		else $error("done too long");
endmodule
bind sbu_top sbu_checker u_chk (.clk, .resetn, .instr_valid, .instr_word, .align_fault, .store_reg, .illegal_reg,
	.busy_reg, .done_reg, .base_updated_reg);

// file: dv/sbu_mem_model.sv
/* data memory store port model
 * assumes one write per store */
`timescale 1ns/1ns
module sbu_mem_model (
	// port
	input wire logic clk,
	input wire sbu_pkg::sbu_store_t st,
	input wire logic fault_cmd,
	output logic align_fault,
	// capture
	output logic [31:0] last_addr,
	output logic [7:0] last_data,
	output int wr_cnt
);
	// faults only on bench command
	assign align_fault = fault_cmd;
	initial wr_cnt = 0;
	always @(posedge clk) if (st.valid) begin
		last_addr <= st.addr;
		last_data <= st.data;
		wr_cnt <= wr_cnt + 1;
	end
endmodule

// file: dv/store_byte_unit_test.sv
/* bench for sbu_top with memory model
 * assumes registers preloaded after reset */
`timescale 1ns/1ns
module store_byte_unit_test;
	typedef struct packed {logic [31:0] w; logic f; logic [31:0] a; logic u;} sbu_row_t;
	logic clk = 0, resetn = 0, instr_valid = 0, fault_cmd = 0;
	logic [31:0] instr_word = 0, last_addr;
	sbu_pkg::sbu_wb_t gpr_load = 0;
	sbu_pkg::sbu_store_t store_reg;
	logic align_fault, illegal_reg, busy_reg, done_reg, base_updated_reg;
	logic [7:0] last_data;
	int wr_cnt, n, error_cnt = 0, tests_run = 0;
	sbu_row_t rows[11] = '{
		'{32'h98c1_fff0, 1'b0, 32'h0000_0ff0, 1'b0},
		'{32'h98c0_0004, 1'b0, 32'h0000_0004, 1'b0},
		'{32'h7cc1_11ae, 1'b0, 32'h0000_1010, 1'b0},
		'{32'h7cc0_11ae, 1'b0, 32'h0000_0010, 1'b0},
		'{32'h9cc1_0008, 1'b0, 32'h0000_1008, 1'b1},
		'{32'h7cc0_09ae, 1'b0, 32'h0000_1008, 1'b0},
		'{32'h7cc1_11ee, 1'b0, 32'h0000_1018, 1'b1},
		'{32'h7cc0_11ee, 1'b0, 32'h0000_0010, 1'b0},
		'{32'h7cc0_31ae, 1'b0, 32'h4865_6c6f, 1'b0},
		'{32'h9cc1_0004, 1'b1, 32'h0000_101c, 1'b0},
		'{32'h7cc0_09ae, 1'b0, 32'h0000_1018, 1'b0}};
	initial forever #5 clk = ~clk;
	sbu_top DUT (.clk, .resetn, .ce(1'b1), .instr_valid, .instr_word, .gpr_load, .align_fault, .store_reg,
		.illegal_reg, .busy_reg, .done_reg, .base_updated_reg);
	sbu_mem_model u_mem (.clk, .st(store_reg), .fault_cmd, .align_fault, .last_addr, .last_data, .wr_cnt);
	task chk(input logic ok);
		tests_run++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("ERROR %0t mismatch", $time);
		end
	endtask
	task end_of_test;
		if (error_cnt == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task load(input logic [4:0] i, input logic [31:0] d);
		@(negedge clk);
		gpr_load = {1'b1, i, d};
	endtask
	task issue(input logic [31:0] w, input logic f);
		@(negedge clk);
		gpr_load.en = 0;
		instr_word = w;
		instr_valid = 1;
		fault_cmd = f;
		n = wr_cnt;
		@(negedge clk);
		instr_valid = 0;
	endtask
	initial begin
		repeat (3) @(negedge clk);
		resetn = 1;
		load(0, 32'h7777_7777);
		load(1, 32'h0000_1000);
		load(2, 32'h0000_0010);
		load(6, 32'h4865_6c6f);
		foreach (rows[k]) begin
			issue(rows[k].w, rows[k].f);
			for (int i = 0; i < 8 && done_reg !== 1'b1; i++) @(negedge clk);
			chk(done_reg);
			if (done_reg !== 1'b1) end_of_test;
			chk(base_updated_reg === rows[k].u);
			@(negedge clk);
			chk(wr_cnt == n + !rows[k].f);
			chk(rows[k].f || last_addr === rows[k].a && last_data === 8'h6f);
		end
		// undecoded extended code next to the indexed one
		issue(32'h7cc1_11ac, 1'b0);
		chk(illegal_reg === 1'b1 && busy_reg === 1'b0);
		end_of_test;
	end
endmodule
